// ---- pkg/i2c_flags_pkg.sv ----
// Constants for the slave status flag block: register map, flag layout, reset values.
// Assumes a 32-bit AXI4-Lite master and a slave port engine on the same clock.
package i2c_flags_pkg;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_RX_DATA = 8'h04;
    localparam logic [7:0] OFS_TX_DATA = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFS_CONTROL = 8'h14;

    // ----------------------------------------
    // Flag layout, shared by status, irq status and mask
    // ----------------------------------------
    localparam int FLAG_W = 7;
    localparam int BIT_BUSY = 0;
    localparam int BIT_NOACK = 1;
    localparam int BIT_RX_OVF = 2;
    localparam int BIT_RX_IRQ = 3;
    localparam int BIT_TX_IRQ = 4;
    localparam int BIT_TX_UNF = 5;
    localparam int BIT_TX_NFULL = 6;

    // Control register: bit 0 flushes the receive FIFO
    localparam int BIT_RX_FLUSH = 0;

    // ----------------------------------------
    // Widths and reset values
    // ----------------------------------------
    localparam int DATA_W = 8;
    localparam logic [FLAG_W-1:0] FLAGS_RST = 7'h00;
    localparam logic [FLAG_W-1:0] MASK_RST = 7'h00;
    localparam logic [DATA_W-1:0] TX_DATA_RST = 8'h00;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- hdl/flag_bank.sv ----
// Bank of sticky flags with per-bit set and clear; set wins over clear.
// Assumes set and clear come from logic on the same clock.
module flag_bank
    import i2c_flags_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Set and clear strobes
    input wire logic [FLAG_W-1:0] set_in,
    input wire logic [FLAG_W-1:0] clr_in,
    // Flag values
    output logic [FLAG_W-1:0] q
);
    logic [FLAG_W-1:0] flag_reg;
    logic [FLAG_W-1:0] flag_next;

    // ----------------------------------------
    // Per-bit next value
    // ----------------------------------------
    for (genvar i = 0; i < FLAG_W; i++) begin : g_bit
        always_comb begin
            flag_next[i] = set_in[i] | (flag_reg[i] & ~clr_in[i]);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_reg <= FLAGS_RST;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign q = flag_reg;
endmodule

// ---- hdl/i2c_slave_flags.sv ----
// Slave status flags of an I2C slave port, with AXI4-Lite register access and one interrupt.
// Assumes the slave port engine and its FIFOs run on aclk and give single-cycle event pulses.
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
module i2c_slave_flags
    import i2c_flags_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // AXI4-Lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read address
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // AXI4-Lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Slave port engine conditions
    input wire logic slave_busy,
    input wire logic read_req_no_data,
    input wire logic rx_byte_done,
    input wire logic tx_done,
    // FIFO conditions
    input wire logic rx_fifo_overflow,
    input wire logic tx_fifo_underflow,
    input wire logic tx_fifo_full,
    input wire logic [i2c_flags_pkg::DATA_W-1:0] rx_fifo_data,
    // FIFO controls
    output logic rx_fifo_pop,
    output logic rx_fifo_flush,
    output logic tx_fifo_push,
    output logic [i2c_flags_pkg::DATA_W-1:0] tx_fifo_data,
    // Interrupt
    output logic irq
);
    import i2c_flags_pkg::*;

    // ----------------------------------------
    // Write channel state
    // ----------------------------------------
    logic aw_hold_reg;
    logic aw_hold_next;
    logic w_hold_reg;
    logic w_hold_next;
    logic [7:0] waddr_reg;
    logic [7:0] waddr_next;
    logic [31:0] wdata_reg;
    logic [31:0] wdata_next;
    logic [3:0] wstrb_reg;
    logic [3:0] wstrb_next;
    logic bvalid_reg;
    logic bvalid_next;
    logic [1:0] bresp_reg;
    logic [1:0] bresp_next;

    logic aw_take;
    logic w_take;
    logic aw_have;
    logic w_have;
    logic do_write;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_hit;

    assign awready = !aw_hold_reg && !bvalid_reg;
    assign wready = !w_hold_reg && !bvalid_reg;
    assign aw_take = awvalid && awready;
    assign w_take = wvalid && wready;
    assign aw_have = aw_hold_reg || aw_take;
    assign w_have = w_hold_reg || w_take;
    assign do_write = aw_have && w_have;
    assign wr_addr = aw_hold_reg ? waddr_reg : awaddr;
    assign wr_data = w_hold_reg ? wdata_reg : wdata;
    assign wr_strb = w_hold_reg ? wstrb_reg : wstrb;

    always_comb begin
        case (wr_addr)
            OFS_STATUS, OFS_RX_DATA, OFS_TX_DATA, OFS_IRQ_STATUS, OFS_IRQ_MASK, OFS_CONTROL: begin
                wr_hit = 1'b1;
            end
            default: begin
                wr_hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        aw_hold_next = aw_hold_reg;
        w_hold_next = w_hold_reg;
        waddr_next = waddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (bvalid_reg && bready) begin
            bvalid_next = 1'b0;
        end
        if (do_write) begin
            aw_hold_next = 1'b0;
            w_hold_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else begin
            if (aw_take) begin
                aw_hold_next = 1'b1;
                waddr_next = awaddr;
            end
            if (w_take) begin
                w_hold_next = 1'b1;
                wdata_next = wdata;
                wstrb_next = wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            waddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else begin
            aw_hold_reg <= aw_hold_next;
            w_hold_reg <= w_hold_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
        end
    end

    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;

    // ----------------------------------------
    // Register write strobes
    // ----------------------------------------
    logic wr_lane0;
    logic wr_status;
    logic wr_tx_data;
    logic wr_irq_status;
    logic wr_irq_mask;
    logic wr_control;

    assign wr_lane0 = do_write && wr_strb[0];
    assign wr_status = do_write && (wr_addr == OFS_STATUS);
    assign wr_tx_data = wr_lane0 && (wr_addr == OFS_TX_DATA);
    assign wr_irq_status = wr_lane0 && (wr_addr == OFS_IRQ_STATUS);
    assign wr_irq_mask = wr_lane0 && (wr_addr == OFS_IRQ_MASK);
    assign wr_control = wr_lane0 && (wr_addr == OFS_CONTROL);

    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    logic rvalid_reg;
    logic rvalid_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [1:0] rresp_reg;
    logic [1:0] rresp_next;
    logic ar_take;
    logic rd_status;
    logic rd_rx_data;

    logic [FLAG_W-1:0] status_q;
    logic [FLAG_W-1:0] irq_status_q;
    logic [FLAG_W-1:0] mask_reg;
    logic [FLAG_W-1:0] mask_next;

    assign arready = !rvalid_reg;
    assign ar_take = arvalid && arready;
    assign rd_status = ar_take && (araddr == OFS_STATUS);
    assign rd_rx_data = ar_take && (araddr == OFS_RX_DATA);

    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (rvalid_reg && rready) begin
            rvalid_next = 1'b0;
        end
        if (ar_take) begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            rdata_next = 32'h0000_0000;
            case (araddr)
                OFS_STATUS: begin
                    rdata_next[FLAG_W-1:0] = status_q;
                end
                OFS_RX_DATA: begin
                    rdata_next[DATA_W-1:0] = rx_fifo_data;
                end
                OFS_TX_DATA: begin
                    rdata_next[DATA_W-1:0] = tx_fifo_data;
                end
                OFS_IRQ_STATUS: begin
                    rdata_next[FLAG_W-1:0] = irq_status_q;
                end
                OFS_IRQ_MASK: begin
                    rdata_next[FLAG_W-1:0] = mask_reg;
                end
                OFS_CONTROL: begin
                    rdata_next = 32'h0000_0000;
                end
                default: begin
                    rresp_next = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else begin
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    logic [FLAG_W-1:0] st_set;
    logic [FLAG_W-1:0] st_clr;

    always_comb begin
        st_set = '0;
        st_clr = '0;
        st_set[BIT_BUSY] = slave_busy;
        st_clr[BIT_BUSY] = !slave_busy;
        st_set[BIT_NOACK] = read_req_no_data;
        st_clr[BIT_NOACK] = rd_status;
        st_set[BIT_RX_OVF] = rx_fifo_overflow;
        st_clr[BIT_RX_OVF] = rd_status;
        st_set[BIT_RX_IRQ] = rx_byte_done;
        st_clr[BIT_RX_IRQ] = rd_rx_data || rx_fifo_flush;
        st_set[BIT_TX_IRQ] = tx_done;
        st_clr[BIT_TX_IRQ] = wr_tx_data;
        st_set[BIT_TX_UNF] = tx_fifo_underflow;
        st_clr[BIT_TX_UNF] = wr_status;
        st_set[BIT_TX_NFULL] = !tx_fifo_full;
        st_clr[BIT_TX_NFULL] = tx_fifo_full;
    end

    flag_bank u_status (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_in(st_set),
        .clr_in(st_clr),
        .q(status_q)
    );

    // ----------------------------------------
    // Interrupt status, mask and output
    // ----------------------------------------
    logic [FLAG_W-1:0] irq_set;
    logic [FLAG_W-1:0] irq_clr;
    logic irq_reg;
    logic irq_next;

    assign irq_set = st_set & ~status_q;
    assign irq_clr = wr_irq_status ? wr_data[FLAG_W-1:0] : '0;

    flag_bank u_irq_status (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_in(irq_set),
        .clr_in(irq_clr),
        .q(irq_status_q)
    );

    always_comb begin
        mask_next = wr_irq_mask ? wr_data[FLAG_W-1:0] : mask_reg;
        irq_next = |(irq_status_q & mask_reg);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_reg <= MASK_RST;
            irq_reg <= 1'b0;
        end else begin
            mask_reg <= mask_next;
            irq_reg <= irq_next;
        end
    end

    assign irq = irq_reg;

    // ----------------------------------------
    // FIFO controls
    // ----------------------------------------
    logic [DATA_W-1:0] tx_data_reg;
    logic [DATA_W-1:0] tx_data_next;
    logic tx_push_reg;
    logic tx_push_next;
    logic pop_reg;
    logic pop_next;
    logic flush_reg;
    logic flush_next;

    always_comb begin
        tx_data_next = wr_tx_data ? wr_data[DATA_W-1:0] : tx_data_reg;
        tx_push_next = wr_tx_data;
        pop_next = rd_rx_data;
        flush_next = wr_control && wr_data[BIT_RX_FLUSH];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_data_reg <= TX_DATA_RST;
            tx_push_reg <= 1'b0;
            pop_reg <= 1'b0;
            flush_reg <= 1'b0;
        end else begin
            tx_data_reg <= tx_data_next;
            tx_push_reg <= tx_push_next;
            pop_reg <= pop_next;
            flush_reg <= flush_next;
        end
    end

    assign tx_fifo_data = tx_data_reg;
    assign tx_fifo_push = tx_push_reg;
    assign rx_fifo_pop = pop_reg;
    assign rx_fifo_flush = flush_reg;
endmodule

// ---- tb/i2c_slave_flags_asserts.sv ----
// Checker of the slave flag block, watching its ports only.
// Assumes one clock aclk and a synchronous active-low aresetn.
module i2c_slave_flags_chk
    import i2c_flags_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    // Engine and FIFO side
    input wire logic slave_busy,
    input wire logic tx_fifo_full,
    input wire logic [DATA_W-1:0] rx_fifo_data,
    input wire logic rx_fifo_pop,
    input wire logic rx_fifo_flush,
    input wire logic tx_fifo_push,
    input wire logic [DATA_W-1:0] tx_fifo_data
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic wr_take;
    logic rd_take;
    logic [7:0] wbyte;
    logic [7:0] head_q;
    assign wr_take = awvalid && awready && wvalid && wready;
    assign rd_take = arvalid && arready;
    always_ff @(posedge aclk) begin
        wbyte <= wdata[7:0];
        head_q <= rx_fifo_data;
    end
    // ------
    // Properties
    // ------
    AST_WRITE_RESP: assert property (wr_take |=> bvalid && !awready && !wready) else $error("write response late");
    AST_READ_RESP: assert property (rd_take |=> rvalid && !arready) else $error("read response late");
    AST_READ_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read answer not held");
    AST_UNMAPPED: assert property (rd_take && araddr > OFS_CONTROL |=> rresp == RESP_SLVERR && rdata == 32'h0)
        else $error("unmapped read answered");
    AST_TX_PUSH: assert property (
        wr_take && awaddr == OFS_TX_DATA && wstrb[0] |=> tx_fifo_push && tx_fifo_data == wbyte)
        else $error("transmit push wrong");
    AST_RX_POP: assert property (
        rd_take && araddr == OFS_RX_DATA |=> rx_fifo_pop && rdata[7:0] == head_q) else $error("receive pop wrong");
    AST_RX_FLUSH: assert property (
        wr_take && awaddr == OFS_CONTROL && wstrb[0] && wdata[BIT_RX_FLUSH] |=> rx_fifo_flush)
        else $error("flush missing");
    AST_BUSY: assert property (
        rd_take && araddr == OFS_STATUS && $past(aresetn) |=> rdata[BIT_BUSY] == $past(slave_busy, 2))
        else $error("busy flag wrong");
    AST_NFULL: assert property (
        rd_take && araddr == OFS_STATUS && $past(aresetn) |=> rdata[BIT_TX_NFULL] == !$past(tx_fifo_full, 2))
        else $error("not-full flag wrong");
endmodule

bind i2c_slave_flags i2c_slave_flags_chk i_chk (.*);

// ---- tb/i2c_master_model.sv ----
// Far side model: an I2C bus master as seen through the slave port engine and its FIFOs.
// Assumes the flag block's FIFO controls on the same clock.
module i2c_master_model #(parameter int RX_DEPTH = 2, parameter int TX_DEPTH = 2) (
    // Clock
    input wire logic aclk,
    // Engine and FIFO conditions
    output logic slave_busy,
    output logic read_req_no_data,
    output logic rx_byte_done,
    output logic tx_done,
    output logic rx_fifo_overflow,
    output logic tx_fifo_underflow,
    output logic tx_fifo_full,
    output logic [7:0] rx_fifo_data,
    // FIFO controls
    input wire logic rx_fifo_pop,
    input wire logic rx_fifo_flush,
    input wire logic tx_fifo_push
);
    int rx_cnt = 0;
    int tx_cnt = 0;
    logic [7:0] head = 8'h00;
    initial {slave_busy, read_req_no_data, rx_byte_done, tx_done, rx_fifo_overflow, tx_fifo_underflow} = '0;
    assign tx_fifo_full = (tx_cnt == TX_DEPTH);
    // Empty FIFO shows a stale, inverted head
    assign rx_fifo_data = (rx_cnt > 0) ? head : ~head;
    always @(posedge aclk) begin
        if (rx_fifo_flush)
            rx_cnt <= 0;
        else
            rx_cnt <= rx_cnt + int'(rx_byte_done && !rx_fifo_overflow) - int'(rx_fifo_pop);
        tx_cnt <= tx_cnt + int'(tx_fifo_push) - int'(tx_done && !tx_fifo_underflow);
    end
    task automatic set_busy(input logic b);
        @(posedge aclk);
        slave_busy <= b;
    endtask
    // Master writes one byte to the slave
    task automatic send_byte(input logic [7:0] b);
        @(posedge aclk);
        if (rx_cnt == 0)
            head <= b;
        slave_busy <= 1'b1;
        rx_byte_done <= 1'b1;
        rx_fifo_overflow <= (rx_cnt == RX_DEPTH);
        @(posedge aclk);
        {rx_byte_done, rx_fifo_overflow, slave_busy} <= '0;
    endtask
    // Master reads one byte from the slave
    task automatic fetch_byte();
        @(posedge aclk);
        slave_busy <= 1'b1;
        tx_done <= 1'b1;
        read_req_no_data <= (tx_cnt == 0);
        tx_fifo_underflow <= (tx_cnt == 0);
        @(posedge aclk);
        {tx_done, read_req_no_data, tx_fifo_underflow, slave_busy} <= '0;
    endtask
endmodule

// ---- tb/i2c_slave_flags_test.sv ----
// Testbench of the slave flag block: register accesses over AXI4-Lite against a bus master model.
// Assumes the model's FIFO depths of two entries.
module i2c_slave_flags_test;
    timeunit 1ns;
    timeprecision 1ps;
    import i2c_flags_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd_data;
    logic slave_busy, read_req_no_data, rx_byte_done, tx_done, rx_fifo_overflow, tx_fifo_underflow, tx_fifo_full;
    logic rx_fifo_pop, rx_fifo_flush, tx_fifo_push;
    logic [7:0] rx_fifo_data, tx_fifo_data;
    int compares = 0;
    int miscompares = 0;
    int cycles = 0;
    logic rd_late = 1'b0;
    i2c_slave_flags i_i2c_slave_flags (.*);
    i2c_master_model i_i2c_master_model (.*);
    initial forever #25 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            report_and_stop();
        end
    end
    // ------
    // Bus tasks and checks
    // ------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask
    // Read; rready offered with the request, or held back until the answer when rd_late is set
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 1'b1, !rd_late};
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid === 1'b1 && rready !== 1'b1) rready <= 1'b1;
        end while (rvalid !== 1'b1 || rready !== 1'b1);
        {rd_data, resp} = {rdata, rresp};
        rready <= 1'b0;
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] exp, input string name);
        rd(a);
        check(name, rd_data, exp);
    endtask
    task automatic report_and_stop();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ------
    // Sequence
    // ------
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        chk(OFS_STATUS, 32'h40, "status");
        chk(OFS_IRQ_MASK, 32'h0, "mask");
        chk(8'h18, 32'h0, "unmapped");
        check("unmapped_rresp", resp, RESP_SLVERR);
        wr(8'h18, 32'h1);
        check("unmapped_bresp", resp, RESP_SLVERR);
        i_i2c_master_model.set_busy(1'b1);
        chk(OFS_STATUS, 32'h41, "status");
        i_i2c_master_model.set_busy(1'b0);
        chk(OFS_STATUS, 32'h40, "status");
        i_i2c_master_model.send_byte(8'ha5);
        chk(OFS_STATUS, 32'h48, "status");
        rd_late <= 1'b1;
        chk(OFS_STATUS, 32'h48, "status");
        rd_late <= 1'b0;
        chk(OFS_RX_DATA, 32'ha5, "rx_data");
        chk(OFS_STATUS, 32'h40, "status");
        repeat (3) i_i2c_master_model.send_byte(8'h5a);
        chk(OFS_STATUS, 32'h4c, "status");
        chk(OFS_STATUS, 32'h48, "status");
        wr(OFS_CONTROL, 32'h1);
        chk(OFS_STATUS, 32'h40, "status");
        i_i2c_master_model.fetch_byte();
        chk(OFS_STATUS, 32'h72, "status");
        chk(OFS_STATUS, 32'h70, "status");
        wr(OFS_STATUS, 32'h0);
        chk(OFS_STATUS, 32'h50, "status");
        wr(OFS_TX_DATA, 32'h3c);
        chk(OFS_STATUS, 32'h40, "status");
        wr(OFS_TX_DATA, 32'hc3);
        chk(OFS_STATUS, 32'h00, "status");
        chk(OFS_TX_DATA, 32'hc3, "tx_data");
        i_i2c_master_model.fetch_byte();
        chk(OFS_STATUS, 32'h50, "status");
        wstrb <= 4'he;
        wr(OFS_TX_DATA, 32'h22);
        wstrb <= 4'hf;
        chk(OFS_STATUS, 32'h50, "status");
        wr(OFS_TX_DATA, 32'h11);
        wr(OFS_IRQ_STATUS, 32'h7f);
        wr(OFS_IRQ_MASK, 32'h10);
        chk(OFS_IRQ_MASK, 32'h10, "mask");
        check("irq", irq, 32'h0);
        i_i2c_master_model.fetch_byte();
        repeat (3) @(posedge aclk);
        check("irq", irq, 32'h1);
        chk(OFS_IRQ_STATUS, 32'h51, "irq_status");
        wr(OFS_IRQ_MASK, 32'h0);
        repeat (2) @(posedge aclk);
        check("irq", irq, 32'h0);
        wr(OFS_IRQ_MASK, 32'h10);
        repeat (2) @(posedge aclk);
        check("irq", irq, 32'h1);
        wr(OFS_IRQ_STATUS, 32'h10);
        repeat (2) @(posedge aclk);
        check("irq", irq, 32'h0);
        report_and_stop();
    end
endmodule
